/* File: rtl/sepr_async_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module sepr_async_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 16
) (
    input wire logic wclk, // fill side clock
    input wire logic wrstn, // fill side reset, low
    input wire logic w_valid, // entry offered
    output logic w_ready, // room for an entry
    input wire logic [W-1:0] w_data, // entry in
    input wire logic rclk, // drain side clock
    input wire logic rrstn, // drain side reset, low
    output logic r_valid, // entry at head
    input wire logic r_ready, // head taken
    output logic [W-1:0] r_data // head entry
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0] bin;
        logic [AW:0] gray;
        logic [AW:0] rs1;
        logic [AW:0] rs2;
    } wr_s;

    typedef struct packed {
        logic [AW:0] bin;
        logic [AW:0] gray;
        logic [AW:0] ws1;
        logic [AW:0] ws2;
    } rd_s;

    wr_s wq, wd;
    rd_s rq, rd;
    logic [AW:0] wnext, rnext;

    // full when write gray is read gray with top two bits inverted
    assign w_ready = wq.gray != {~wq.rs2[AW:AW-1], wq.rs2[AW-2:0]};
    assign r_valid = rq.gray != rq.ws2;
    assign r_data = wq.mem[rq.bin[AW-1:0]];

    always_comb begin
        wd = wq;
        wnext = wq.bin + 1'b1;
        wd.rs1 = rq.gray;
        wd.rs2 = wq.rs1;
        if (w_valid && w_ready) begin
            wd.mem[wq.bin[AW-1:0]] = w_data;
            wd.bin = wnext;
            wd.gray = wnext ^ (wnext >> 1);
        end
    end

    always_ff @(posedge wclk) begin
        if (!wrstn) begin
            wq <= '0;
        end else begin
            wq <= wd;
        end
    end

    always_comb begin
        rd = rq;
        rnext = rq.bin + 1'b1;
        rd.ws1 = wq.gray;
        rd.ws2 = rq.ws1;
        if (r_valid && r_ready) begin
            rd.bin = rnext;
            rd.gray = rnext ^ (rnext >> 1);
        end
    end

    always_ff @(posedge rclk) begin
        if (!rrstn) begin
            rq <= '0;
        end else begin
            rq <= rd;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/sepr_pkg.sv */
package sepr_pkg;
    localparam int CLK_NS = 4;
    localparam int FILT_NS = 100;
    // a pulse must outlast the filter window to count as an edge
    localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS + 1;
    localparam int CNT_W = 5;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int SCL = 0;
    localparam int SDA = 1;
    localparam int RNW_BIT = 0;
    localparam int SEL_LSB = 1;
    localparam int TYPE_LSB = 4;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    // arbitrary value, override per product
    localparam logic [3:0] DEV_TYPE_DEF = 4'h5;

    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ACK_DEV, S_WADDR, S_ACK_WADDR, S_IGNORE, S_LOAD, S_TX, S_RX_ACK
    } sepr_state_e;

    typedef enum logic [1:0] {L_IDLE, L_READ, L_CAP, L_PUSH} sepr_lstate_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } sepr_entry_s;

    typedef struct packed {
        logic [2:0][1:0] sync;
        logic [2:0][2:0] ssel;
        logic [2:0] sel;
        logic [1:0][CNT_W-1:0] cnt;
        logic [1:0] filt;
        logic [1:0] fprev;
        sepr_state_e st;
        logic [3:0] bitn;
        logic [DATA_W-1:0] sh;
        logic [ADDR_W-1:0] addr;
        logic rnw;
        logic ack;
        logic oe;
        logic req;
        logic infl;
        logic [ADDR_W-1:0] req_addr;
    } sepr_core_s;

    typedef struct packed {
        logic [2:0] sync;
        logic seen;
        sepr_lstate_e st;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } sepr_link_s;
endpackage

/* File: rtl/sepr_read_path.sv */
// How it works
// RULE_01 - addressing byte with direction high means read
// RULE_02 - counter holds n+1 after access n
// RULE_03 - matching read address acked, then byte sent
// RULE_04 - master ends read with no-ack then STOP
// RULE_05 - random read starts with dummy write address
// RULE_06 - dummy write loads counter, acked, nothing written
// RULE_07 - master then reads at the loaded address
// RULE_08 - sequential read starts either way alike
// RULE_09 - each master ack asks for another byte
// RULE_10 - counter steps one per byte sent
// RULE_11 - counter wraps from 255 to 0
// RULE_12 - glitches up to 100 ns filtered out
// RULE_13 - output bit changes on clock falling edge
// RULE_14 - ninth clock carries the acknowledge
// RULE_15 - type code, select pins, direction bit
// RULE_16 - mismatch or no-ack: release, await START
// RULE_17 - repeated START restarts, counter kept
`timescale 1ns/1ps
`default_nettype none
module sepr_read_path #(
    parameter logic [3:0] DEV_TYPE = sepr_pkg::DEV_TYPE_DEF,
    parameter int DEPTH = sepr_pkg::FIFO_DEPTH
) (
    input wire logic clk, // core clock
    input wire logic rstn, // core reset, low
    input wire logic link_clk, // array side clock
    input wire logic link_rstn, // array side reset, low
    input wire logic scl_i, // serial clock pin
    input wire logic sda_i, // serial data pin level
    output logic sda_o, // serial data drive value
    output logic sda_oe, // serial data pulled low
    input wire logic select_pin_0, // device select strap
    input wire logic select_pin_1, // device select strap
    input wire logic select_pin_2, // device select strap
    output logic [sepr_pkg::ADDR_W-1:0] mem_addr, // array read address
    output logic mem_rd, // array read strobe
    input wire logic [sepr_pkg::DATA_W-1:0] mem_rdata // array data, one cycle after strobe
);
    import sepr_pkg::*;

    sepr_core_s q, d;
    sepr_link_s lq, ld;
    sepr_entry_s r_data, w_data;
    logic r_valid, r_ready, w_valid, w_ready;
    logic scl_rise, scl_fall, start_w, stop_w, head_ok, match_w, pop;

    // prefetched bytes travel from the array clock to the core clock
    sepr_async_fifo #(
        .W($bits(sepr_entry_s)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .wclk(link_clk),
        .wrstn(link_rstn),
        .w_valid(w_valid),
        .w_ready(w_ready),
        .w_data(w_data),
        .rclk(clk),
        .rrstn(rstn),
        .r_valid(r_valid),
        .r_ready(r_ready),
        .r_data(r_data)
    );

    assign scl_rise = q.filt[SCL] && !q.fprev[SCL];
    assign scl_fall = !q.filt[SCL] && q.fprev[SCL];
    assign start_w = q.filt[SCL] && q.fprev[SCL] && q.fprev[SDA] && !q.filt[SDA];
    assign stop_w = q.filt[SCL] && q.fprev[SCL] && !q.fprev[SDA] && q.filt[SDA];
    // [RULE_15]
    assign match_w = q.sh[TYPE_LSB +: 4] == DEV_TYPE && q.sh[SEL_LSB +: 3] == q.sel;
    assign head_ok = r_valid && r_data.addr == q.addr;
    assign r_ready = pop;
    assign sda_o = 1'b0;
    assign sda_oe = q.oe;

    always_comb begin
        d = q;
        pop = 1'b0;
        d.sync = {q.sync[1:0], {sda_i, scl_i}};
        d.ssel = {q.ssel[1:0], {select_pin_2, select_pin_1, select_pin_0}};
        if (q.ssel[1] == q.ssel[2]) begin
            d.sel = q.ssel[2];
        end
        d.fprev = q.filt;
        for (int i = 0; i < 2; i++) begin
            if (q.sync[1][i] == q.sync[2][i] && q.sync[2][i] != q.filt[i]) begin
                if (q.cnt[i] == CNT_W'(FILT_CYC - 1)) begin
                    d.filt[i] = q.sync[2][i]; // [RULE_12]
                    d.cnt[i] = '0;
                end else begin
                    d.cnt[i] = q.cnt[i] + 1'b1;
                end
            end else begin
                d.cnt[i] = '0; // [RULE_12]
            end
        end
        // stale prefetch after an address load is thrown away
        if (r_valid && !head_ok) begin
            pop = 1'b1;
        end
        case (q.st)
            S_ADDR, S_WADDR: begin
                if (scl_rise) begin
                    d.sh = {q.sh[DATA_W-2:0], q.filt[SDA]};
                    d.bitn = q.bitn + 1'b1;
                end
                if (scl_fall && q.bitn == BYTE_BITS) begin
                    if (q.st == S_WADDR) begin
                        d.addr = q.sh; // [RULE_06]
                        d.oe = 1'b1;
                        d.st = S_ACK_WADDR;
                    end else if (match_w) begin
                        d.oe = 1'b1; // [RULE_03] [RULE_14]
                        d.rnw = q.sh[RNW_BIT]; // [RULE_01]
                        d.st = S_ACK_DEV;
                    end else begin
                        d.st = S_IGNORE; // [RULE_16]
                    end
                end
            end
            S_ACK_DEV: begin
                if (scl_fall) begin
                    d.oe = 1'b0;
                    d.bitn = '0;
                    // [RULE_08]
                    d.st = q.rnw ? S_LOAD : S_WADDR; // [RULE_05]
                end
            end
            S_ACK_WADDR: begin
                if (scl_fall) begin
                    d.oe = 1'b0;
                    d.st = S_IGNORE; // [RULE_06]
                end
            end
            S_LOAD: begin
                // only load while the clock is low, else a fake START or STOP would follow
                if (head_ok && !q.filt[SCL]) begin
                    pop = 1'b1;
                    d.sh = r_data.data; // [RULE_03] [RULE_07]
                    d.addr = q.addr + 1'b1; // [RULE_02] [RULE_10] [RULE_11]
                    d.oe = !r_data.data[DATA_W-1];
                    d.bitn = '0;
                    d.st = S_TX;
                end
            end
            S_TX: begin
                if (scl_fall) begin
                    if (q.bitn == LAST_BIT) begin
                        d.oe = 1'b0; // [RULE_14]
                        d.st = S_RX_ACK;
                    end else begin
                        d.bitn = q.bitn + 1'b1;
                        d.sh = {q.sh[DATA_W-2:0], 1'b0};
                        d.oe = !q.sh[DATA_W-2]; // [RULE_13]
                    end
                end
            end
            S_RX_ACK: begin
                if (scl_rise) begin
                    d.ack = !q.filt[SDA];
                end
                if (scl_fall) begin
                    d.st = q.ack ? S_LOAD : S_IDLE; // [RULE_09] [RULE_04] [RULE_16]
                end
            end
            default: begin
            end
        endcase
        if (start_w) begin
            d.st = S_ADDR; // [RULE_17]
            d.bitn = '0;
            d.oe = 1'b0;
        end else if (stop_w) begin
            d.st = S_IDLE; // [RULE_16]
            d.oe = 1'b0;
        end
        if (pop) begin
            d.infl = 1'b0;
        end
        // keep exactly one fetch of the current counter value in flight
        if (!d.infl) begin
            d.req = !q.req;
            d.req_addr = d.addr;
            d.infl = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= '0;
            q.filt <= 2'h3;
            q.fprev <= 2'h3;
            q.sync <= '1;
            q.st <= S_IDLE;
        end else begin
            q <= d;
        end
    end

    assign mem_addr = lq.addr;
    assign mem_rd = lq.st == L_READ;
    assign w_valid = lq.st == L_PUSH;
    assign w_data = '{addr: lq.addr, data: lq.data};

    always_comb begin
        ld = lq;
        ld.sync = {lq.sync[1:0], q.req};
        case (lq.st)
            L_IDLE: begin
                if (lq.sync[2] != lq.seen && lq.sync[1] == lq.sync[2]) begin
                    ld.seen = lq.sync[2];
                    // request word is held steady until its entry is popped
                    ld.addr = q.req_addr;
                    ld.st = L_READ;
                end
            end
            L_READ: begin
                ld.st = L_CAP;
            end
            L_CAP: begin
                ld.data = mem_rdata;
                ld.st = L_PUSH;
            end
            L_PUSH: begin
                if (w_ready) begin
                    ld.st = L_IDLE;
                end
            end
            default: begin
                ld.st = L_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk) begin
        if (!link_rstn) begin
            lq <= '0;
            lq.st <= L_IDLE;
        end else begin
            lq <= ld;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_ack_on_match: assert property ( // [RULE_03]
        q.st == S_ADDR && scl_fall && q.bitn == BYTE_BITS && match_w && q.sh[RNW_BIT]
        && !start_w && !stop_w |=> sda_oe && q.st == S_ACK_DEV ##1 sda_oe)
        else $error("no acknowledge for a matching read address");
    a_waddr_load: assert property ( // [RULE_06]
        q.st == S_WADDR && scl_fall && q.bitn == BYTE_BITS && !start_w && !stop_w
        |=> q.addr == $past(q.sh) && sda_oe)
        else $error("word address not loaded into the counter");
    a_addr_step: assert property ( // [RULE_02]
        q.st == S_LOAD && d.st == S_TX |=> q.addr == $past(q.addr) + 8'h01)
        else $error("counter did not step after a byte was fetched");
    a_addr_wrap: assert property ( // [RULE_11]
        q.st == S_LOAD && d.st == S_TX && q.addr == 8'hFF |=> q.addr == 8'h00)
        else $error("counter did not wrap to zero");
    a_hold_high: assert property ( // [RULE_13]
        q.filt[SCL] && q.fprev[SCL] && !start_w && !stop_w && q.st == S_TX |=> $stable(sda_oe))
        else $error("data changed while the clock was high");
    a_release_ninth: assert property ( // [RULE_14]
        q.st == S_TX && scl_fall && q.bitn == LAST_BIT && !start_w && !stop_w
        |=> !sda_oe && q.st == S_RX_ACK)
        else $error("line not released for the acknowledge bit");
    a_nack_idle: assert property ( // [RULE_16]
        q.st == S_RX_ACK && scl_fall && !q.ack && !start_w && !stop_w
        |=> q.st == S_IDLE && !sda_oe)
        else $error("no-acknowledge did not end the read");
    a_ack_more: assert property ( // [RULE_09]
        q.st == S_RX_ACK && scl_fall && q.ack && !start_w && !stop_w |=> q.st == S_LOAD)
        else $error("acknowledge did not ask for another byte");
    a_restart_keep: assert property ( // [RULE_17]
        start_w |=> q.st == S_ADDR && !sda_oe && q.bitn == 4'h0 && q.addr == $past(q.addr))
        else $error("repeated start did not restart cleanly");
    a_glitch_filter: assert property ( // [RULE_12]
        q.filt[SDA] != $past(q.filt[SDA]) |-> $past(q.cnt[SDA]) == CNT_W'(FILT_CYC - 1))
        else $error("data input changed before the filter window");
    a_mismatch_free: assert property ( // [RULE_16]
        q.st == S_ADDR && scl_fall && q.bitn == BYTE_BITS && !match_w && !start_w && !stop_w
        |=> (q.st == S_IGNORE && !sda_oe) [*2])
        else $error("mismatched address not ignored");
endmodule
`default_nettype wire

/* File: testbench/sepr_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sepr_master_model (
    input wire logic clk, // pacing clock
    output logic scl, // serial clock, master owned
    output logic sda_low, // master pulls data low
    input wire logic sda, // resolved data line
    input wire logic link_clk, // array clock
    input wire logic [sepr_pkg::ADDR_W-1:0] mem_addr, // array address
    input wire logic mem_rd, // array strobe
    output logic [sepr_pkg::DATA_W-1:0] mem_rdata // array data
);
    import sepr_pkg::*;
    localparam int Q = 75;
    int bad = 0;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        mem_rdata = 8'h00;
    end
    // data only valid the cycle after the strobe, garbage otherwise
    always @(posedge link_clk) begin
        mem_rdata <= mem_rd ? (mem_addr ^ 8'h5A) : ~mem_rdata;
    end
    task automatic wq(input int n);
        repeat (n * Q) @(negedge clk);
    endtask
    task automatic start_c();
        wq(1);
        sda_low = 1'b0;
        wq(1);
        scl = 1'b1;
        wq(2);
        sda_low = 1'b1;
        wq(2);
        scl = 1'b0;
    endtask
    task automatic stop_c();
        wq(1);
        sda_low = 1'b1;
        wq(1);
        scl = 1'b1;
        wq(2);
        sda_low = 1'b0;
        wq(2);
    endtask
    task automatic bit_x(input logic b, output logic r);
        logic r0;
        wq(1);
        sda_low = ~b;
        wq(3);
        scl = 1'b1;
        wq(1);
        r0 = sda;
        wq(1);
        r = sda;
        if (r !== r0) bad++;
        scl = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(~more, r);
    endtask
    // 60 ns pulse, below the noise window
    task automatic glitch();
        wq(1);
        scl = 1'b1;
        repeat (15) @(negedge clk);
        scl = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: testbench/sepr_read_path_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sepr_read_path_tb_top;
    import sepr_pkg::*;
    localparam logic [3:0] DT = 4'h9; // arbitrary type code
    localparam logic [2:0] SEL = 3'h5;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rstn = 1'b0;
    logic link_rstn = 1'b0;
    logic [2:0] sel_pins = SEL;
    logic scl, m_low, sda_o, sda_oe, mem_rd;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] mem_rdata;
    wire sda_w;
    int err_total = 0;
    int checks_done = 0;
    logic [7:0] ctr = 8'h00;
    // open drain with pull-up
    assign sda_w = !(m_low || (sda_oe && !sda_o));
    initial begin
        forever #2 clk = ~clk;
    end
    initial begin
        #37;
        forever #80 link_clk = ~link_clk;
    end
    sepr_read_path #(.DEV_TYPE(DT), .DEPTH(16)) dut (
        .clk(clk), .rstn(rstn), .link_clk(link_clk), .link_rstn(link_rstn),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .select_pin_0(sel_pins[0]), .select_pin_1(sel_pins[1]),
        .select_pin_2(sel_pins[2]), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata)
    );
    sepr_master_model m (
        .clk(clk), .scl(scl), .sda_low(m_low), .sda(sda_w), .link_clk(link_clk),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata)
    );
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d, errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic addr_ack(input logic [7:0] b, input logic exp);
        logic a;
        m.wbyte(b, a);
        chk({7'h00, a}, {7'h00, exp});
    endtask
    task automatic rd_exp(input logic more);
        logic [7:0] d;
        m.rbyte(more, d);
        chk(d, ctr ^ 8'h5A);
        ctr++;
    endtask
    task automatic s_random_wrap();
        m.start_c();
        addr_ack({DT, SEL, 1'b0}, 1'b1);
        addr_ack(8'hFE, 1'b1);
        ctr = 8'hFE;
        m.start_c();
        addr_ack({DT, SEL, 1'b1}, 1'b1);
        rd_exp(1'b1);
        rd_exp(1'b1);
        rd_exp(1'b0);
        m.stop_c();
    endtask
    task automatic s_current();
        m.start_c();
        addr_ack({DT, SEL, 1'b1}, 1'b1);
        rd_exp(1'b0);
        m.stop_c();
        chk({7'h00, sda_w}, 8'h01);
    endtask
    task automatic s_wrong_id();
        m.start_c();
        addr_ack({DT, SEL ^ 3'h4, 1'b1}, 1'b0);
        m.start_c();
        addr_ack({~DT, SEL, 1'b1}, 1'b0);
        m.stop_c();
    endtask
    task automatic s_glitch();
        m.start_c();
        addr_ack({DT, SEL, 1'b1}, 1'b1);
        m.glitch();
        rd_exp(1'b0);
        m.stop_c();
    endtask
    // word address cut short: counter must survive
    task automatic s_restart();
        logic r;
        m.start_c();
        addr_ack({DT, SEL, 1'b0}, 1'b1);
        for (int i = 0; i < 4; i++) begin
            m.bit_x(1'b0, r);
        end
        m.start_c();
        addr_ack({DT, SEL, 1'b1}, 1'b1);
        rd_exp(1'b0);
        m.stop_c();
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        repeat (80) @(negedge clk);
        link_rstn = 1'b1;
        repeat (500) @(negedge clk);
        s_random_wrap();
        s_current();
        s_wrong_id();
        s_glitch();
        s_restart();
        chk(8'(m.bad), 8'h00);
        report_and_stop();
    end
    initial begin
        repeat (97000) @(posedge clk);
        err_total++;
        $display("MISMATCH at %0t: run did not finish", $time);
        report_and_stop();
    end
endmodule
`default_nettype wire
